// File: shared/qlst_pkg.sv
package qlst_pkg;
  // Management register indices
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_GCFG = 5'h10;
  localparam logic [4:0] REG_LCFG_A = 5'h11;
  localparam logic [4:0] REG_LCFG_D = 5'h14;
  localparam logic [4:0] REG_LANE_STAT = 5'h16;
  localparam logic [4:0] REG_ALIGN_STAT = 5'h17;
  // Field positions
  localparam int CTRL_LOOP_BIT = 14;
  localparam int CFG_LOOP_BIT = 3;
  localparam int CFG_PINSEL_LO = 9;
  localparam int TXCOL_LO = 12;
  localparam int DECERR_LO = 8;
  localparam int PRBS_LO = 4;
  localparam int LOSS_LO = 0;
  localparam int ALIGN_BIT = 4;
  localparam int RXCOL_LO = 0;
  // Reset values
  localparam logic [15:0] LANE_STAT_RST = 16'h00f0;
  localparam logic [4:0] ALIGN_STAT_RST = 5'h00;
  // Multifunction pin selections
  localparam logic [1:0] PINSEL_IOMODE = 2'h0;
  localparam logic [1:0] PINSEL_COMMA = 2'h1;
  localparam logic [1:0] PINSEL_LOSS = 2'h2;
  localparam logic [1:0] PINSEL_PRBS = 2'h3;
  // Management frame
  localparam logic [5:0] PREAMBLE_MIN = 6'h20;
  localparam logic [4:0] HDR_LAST = 5'h0d;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  localparam logic [1:0] FRAME_START = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  // Power-on reset timing
  localparam int CLK_MHZ = 250;
  localparam int POR_TIME_US = 1000;
  // Status output trails the count by one flop; total must stay strictly under the limit
  localparam int POR_MAX_CYCLES = POR_TIME_US * CLK_MHZ - 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HDR,
    ST_TA,
    ST_RD,
    ST_WR
  } qlst_mdio_e;
endpackage

// File: rtl/qlst_status_ctrl.sv
// How it works
// - Each lane's transmit FIFO collision flag (bits 15..12) sets on a collision and clears on read.
// - Each lane's decode error flag (bits 11..8) sets on a bad code or disparity and clears on read.
// - Each lane's test pass flag (bits 7..4) starts at one, drops on a pattern error, and returns to one on read.
// - Each lane's signal-loss flag (bits 3..0) starts at zero, sets on loss of signal, and clears on read.
// - The alignment flag at bit 4 of the alignment register sets when the align code is seen on all lanes and clears on read.
// - Each lane's receive FIFO collision flag (bits 3..0 of the alignment register) sets on a collision and clears on read.
// - A low enable pin powers everything down and floats the serial and parallel outputs of all lanes.
// - A lane's loopback pin or its configuration bit 3 routes its serial transmit data into its own receiver.
// - A lane in loopback keeps its serial output floating.
// - During power-on reset the receive data is held high and floating and the recovered clocks are held low.
// - Power-on reset ends after a count of reference clock cycles that stays under one millisecond.
// - Each lane's multifunction pin can mirror its signal-loss flag or its test pass flag.
// - Each lane's loopback bit is ORed with the global loopback bit 14 of the control register.
`timescale 1ns/10ps
`default_nettype none
module qlst_status_ctrl #(
  parameter int POR_CYCLES = qlst_pkg::POR_MAX_CYCLES,
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic mdcPin,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic enablePin,
  input wire logic ioModeHstlPin,
  input wire logic [3:0] laneLoopbackPin,
  input wire logic [3:0] txFifoCollision,
  input wire logic [3:0] decodeError,
  input wire logic [3:0] prbsError,
  input wire logic [3:0] signalLossEvent,
  input wire logic alignSeen,
  input wire logic [3:0] rxFifoCollision,
  input wire logic [3:0] commaDetect,
  output logic powerDown,
  output logic porActive,
  output logic [3:0] loopbackEn,
  output logic [3:0] txSerialOe,
  output logic [3:0] rxParallelDataOe,
  output logic rxParallelDataHigh,
  output logic [3:0] rxRecoveredClockEn,
  output logic [3:0] multifunctionPin
);
  localparam int POR_W = $clog2(POR_CYCLES + 1);

  if (POR_CYCLES < 1 || POR_CYCLES > qlst_pkg::POR_MAX_CYCLES) begin : g_por_check
    $error("POR_CYCLES out of range");
  end

  logic [7:0] syncA_r;
  logic [7:0] syncB_r;
  logic mdcD_r;
  logic mdcRise;
  logic mdioBit;
  logic enSync;
  logic hstlSync;
  logic [3:0] loopPinSync;
  qlst_pkg::qlst_mdio_e state_r;
  logic [5:0] preCnt_r;
  logic [4:0] bitCnt_r;
  logic [13:0] hdr_r;
  logic [13:0] hdrNxt;
  logic [15:0] shift_r;
  logic [4:0] regAddr_r;
  logic isRead_r;
  logic [15:0] rdData;
  logic rdLoad;
  logic wrStb;
  logic [15:0] wrData;
  logic clrLane;
  logic clrAlign;
  logic ctrlLoop_r;
  logic [1:0] gPinSel_r;
  logic [3:0] cfgLoop_r;
  logic [1:0] cfgPinSel_r [0:3];
  logic [15:0] laneStat_r;
  logic [4:0] alignStat_r;
  logic [POR_W-1:0] porCnt_r;
  logic porDone_r;
  logic [3:0] laneLoop;
  logic [1:0] laneIdx;
  logic [1:0] pinSel [0:3];
  logic pdNow;

  // Pins and the management clock come from outside this domain
  always_ff @(posedge clk) begin
    if (!rstn) begin
      syncA_r <= 8'h00;
      syncB_r <= 8'h00;
      mdcD_r <= 1'b0;
    end else begin
      syncA_r <= {laneLoopbackPin, ioModeHstlPin, enablePin, mdioIn, mdcPin};
      syncB_r <= syncA_r;
      mdcD_r <= syncB_r[0];
    end
  end

  assign mdcRise = syncB_r[0] & ~mdcD_r;
  assign mdioBit = syncB_r[1];
  assign enSync = syncB_r[2];
  assign hstlSync = syncB_r[3];
  assign loopPinSync = syncB_r[7:4];
  assign hdrNxt = {hdr_r[12:0], mdioBit};
  assign rdLoad = mdcRise && state_r == qlst_pkg::ST_TA && isRead_r && bitCnt_r == 5'h01;
  assign wrStb = mdcRise && state_r == qlst_pkg::ST_WR && bitCnt_r == qlst_pkg::DATA_LAST;
  assign wrData = {shift_r[14:0], mdioBit};
  assign clrLane = rdLoad && regAddr_r == qlst_pkg::REG_LANE_STAT;
  assign clrAlign = rdLoad && regAddr_r == qlst_pkg::REG_ALIGN_STAT;
  assign laneIdx = 2'(regAddr_r - qlst_pkg::REG_LCFG_A);

  // Management frame: output changes just after the sampled rising edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= qlst_pkg::ST_IDLE;
      preCnt_r <= 6'h00;
      bitCnt_r <= 5'h00;
      hdr_r <= 14'h0000;
      shift_r <= 16'h0000;
      regAddr_r <= 5'h00;
      isRead_r <= 1'b0;
      mdioOut <= 1'b1;
      mdioOe <= 1'b0;
    end else if (mdcRise) begin
      case (state_r)
        qlst_pkg::ST_IDLE: begin
          if (mdioBit) begin
            if (preCnt_r != qlst_pkg::PREAMBLE_MIN) begin
              preCnt_r <= preCnt_r + 6'h01;
            end
          end else if (preCnt_r == qlst_pkg::PREAMBLE_MIN) begin
            state_r <= qlst_pkg::ST_HDR;
            hdr_r <= 14'h0000;
            bitCnt_r <= 5'h01;
          end else begin
            preCnt_r <= 6'h00;
          end
        end
        qlst_pkg::ST_HDR: begin
          hdr_r <= hdrNxt;
          bitCnt_r <= bitCnt_r + 5'h01;
          if (bitCnt_r == qlst_pkg::HDR_LAST) begin
            bitCnt_r <= 5'h00;
            regAddr_r <= hdrNxt[4:0];
            isRead_r <= hdrNxt[11:10] == qlst_pkg::OP_READ;
            if (hdrNxt[13:12] == qlst_pkg::FRAME_START && hdrNxt[9:5] == PHY_ADDR &&
                (hdrNxt[11:10] == qlst_pkg::OP_READ || hdrNxt[11:10] == qlst_pkg::OP_WRITE)) begin
              state_r <= qlst_pkg::ST_TA;
            end else begin
              state_r <= qlst_pkg::ST_IDLE;
              preCnt_r <= 6'h00;
            end
          end
        end
        qlst_pkg::ST_TA: begin
          bitCnt_r <= bitCnt_r + 5'h01;
          if (bitCnt_r == 5'h00) begin
            mdioOe <= isRead_r;
            mdioOut <= ~isRead_r;
          end else begin
            bitCnt_r <= 5'h00;
            if (isRead_r) begin
              shift_r <= rdData;
              mdioOut <= rdData[15];
              state_r <= qlst_pkg::ST_RD;
            end else begin
              state_r <= qlst_pkg::ST_WR;
            end
          end
        end
        qlst_pkg::ST_RD: begin
          if (bitCnt_r == qlst_pkg::DATA_LAST) begin
            mdioOe <= 1'b0;
            mdioOut <= 1'b1;
            state_r <= qlst_pkg::ST_IDLE;
            preCnt_r <= 6'h00;
          end else begin
            shift_r <= {shift_r[14:0], 1'b0};
            mdioOut <= shift_r[14];
            bitCnt_r <= bitCnt_r + 5'h01;
          end
        end
        qlst_pkg::ST_WR: begin
          shift_r <= wrData;
          bitCnt_r <= bitCnt_r + 5'h01;
          if (bitCnt_r == qlst_pkg::DATA_LAST) begin
            state_r <= qlst_pkg::ST_IDLE;
            preCnt_r <= 6'h00;
          end
        end
        default: begin
          state_r <= qlst_pkg::ST_IDLE;
          mdioOe <= 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    rdData = 16'h0000;
    if (regAddr_r == qlst_pkg::REG_CTRL) begin
      rdData[qlst_pkg::CTRL_LOOP_BIT] = ctrlLoop_r;
    end else if (regAddr_r == qlst_pkg::REG_GCFG) begin
      rdData[qlst_pkg::CFG_PINSEL_LO +: 2] = gPinSel_r;
    end else if (regAddr_r >= qlst_pkg::REG_LCFG_A && regAddr_r <= qlst_pkg::REG_LCFG_D) begin
      rdData[qlst_pkg::CFG_PINSEL_LO +: 2] = cfgPinSel_r[laneIdx];
      rdData[qlst_pkg::CFG_LOOP_BIT] = cfgLoop_r[laneIdx];
    end else if (regAddr_r == qlst_pkg::REG_LANE_STAT) begin
      rdData = laneStat_r;
    end else if (regAddr_r == qlst_pkg::REG_ALIGN_STAT) begin
      rdData[4:0] = alignStat_r;
    end
  end

  // Only the bits this block acts on are stored; the rest read as zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrlLoop_r <= 1'b0;
      gPinSel_r <= qlst_pkg::PINSEL_IOMODE;
      cfgLoop_r <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        cfgPinSel_r[i] <= qlst_pkg::PINSEL_IOMODE;
      end
    end else if (wrStb) begin
      if (regAddr_r == qlst_pkg::REG_CTRL) begin
        ctrlLoop_r <= wrData[qlst_pkg::CTRL_LOOP_BIT];
      end else if (regAddr_r == qlst_pkg::REG_GCFG) begin
        gPinSel_r <= wrData[qlst_pkg::CFG_PINSEL_LO +: 2];
      end else if (regAddr_r >= qlst_pkg::REG_LCFG_A && regAddr_r <= qlst_pkg::REG_LCFG_D) begin
        cfgPinSel_r[laneIdx] <= wrData[qlst_pkg::CFG_PINSEL_LO +: 2];
        cfgLoop_r[laneIdx] <= wrData[qlst_pkg::CFG_LOOP_BIT];
      end
    end
  end

  // Event wins over the clearing read, so nothing is lost
  always_ff @(posedge clk) begin
    if (!rstn) begin
      laneStat_r <= qlst_pkg::LANE_STAT_RST;
    end else begin
      laneStat_r[qlst_pkg::TXCOL_LO +: 4] <=
        (laneStat_r[qlst_pkg::TXCOL_LO +: 4] & ~{4{clrLane}}) | txFifoCollision;
      laneStat_r[qlst_pkg::DECERR_LO +: 4] <=
        (laneStat_r[qlst_pkg::DECERR_LO +: 4] & ~{4{clrLane}}) | decodeError;
      laneStat_r[qlst_pkg::PRBS_LO +: 4] <=
        (laneStat_r[qlst_pkg::PRBS_LO +: 4] | {4{clrLane}}) & ~prbsError;
      laneStat_r[qlst_pkg::LOSS_LO +: 4] <=
        (laneStat_r[qlst_pkg::LOSS_LO +: 4] & ~{4{clrLane}}) | signalLossEvent;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      alignStat_r <= qlst_pkg::ALIGN_STAT_RST;
    end else begin
      alignStat_r[qlst_pkg::ALIGN_BIT] <=
        (alignStat_r[qlst_pkg::ALIGN_BIT] & ~clrAlign) | alignSeen;
      alignStat_r[qlst_pkg::RXCOL_LO +: 4] <=
        (alignStat_r[qlst_pkg::RXCOL_LO +: 4] & ~{4{clrAlign}}) | rxFifoCollision;
    end
  end

  // Reset counts reference cycles, so its length scales with the clock
  always_ff @(posedge clk) begin
    if (!rstn) begin
      porCnt_r <= '0;
      porDone_r <= 1'b0;
    end else if (!porDone_r) begin
      if (porCnt_r == POR_W'(POR_CYCLES - 1)) begin
        porDone_r <= 1'b1;
      end else begin
        porCnt_r <= porCnt_r + POR_W'(1);
      end
    end
  end

  assign laneLoop = loopPinSync | cfgLoop_r | {4{ctrlLoop_r}};
  assign pdNow = ~enSync;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      powerDown <= 1'b1;
      porActive <= 1'b1;
      loopbackEn <= 4'h0;
      txSerialOe <= 4'h0;
      rxParallelDataOe <= 4'h0;
      rxParallelDataHigh <= 1'b1;
      rxRecoveredClockEn <= 4'h0;
    end else begin
      powerDown <= pdNow;
      porActive <= ~porDone_r;
      loopbackEn <= laneLoop & {4{~pdNow}};
      txSerialOe <= ~laneLoop & {4{~pdNow & porDone_r}};
      rxParallelDataOe <= {4{~pdNow & porDone_r}};
      rxParallelDataHigh <= ~porDone_r;
      rxRecoveredClockEn <= {4{~pdNow & porDone_r}};
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_pinsel
    assign pinSel[g] = cfgPinSel_r[g] | gPinSel_r;
  end

  // One process for all lanes, so the output vector has a single driver
  always_ff @(posedge clk) begin
    if (!rstn) begin
      multifunctionPin <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        case (pinSel[i])
          qlst_pkg::PINSEL_IOMODE: multifunctionPin[i] <= hstlSync;
          qlst_pkg::PINSEL_COMMA: multifunctionPin[i] <= commaDetect[i];
          qlst_pkg::PINSEL_LOSS: begin
            multifunctionPin[i] <= laneStat_r[qlst_pkg::LOSS_LO + i];
          end
          qlst_pkg::PINSEL_PRBS: begin
            multifunctionPin[i] <= laneStat_r[qlst_pkg::PRBS_LO + i];
          end
          default: multifunctionPin[i] <= 1'b0;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence porFinish;
    !porDone_r ##1 porDone_r;
  endsequence

  sequence taDrive;
    mdcRise && state_r == qlst_pkg::ST_TA && isRead_r && bitCnt_r == 5'h00;
  endsequence

  txColSet_a: assert property (txFifoCollision != 4'h0 |=>
    (laneStat_r[15:12] & $past(txFifoCollision)) == $past(txFifoCollision))
    else $error("tx collision flag not set");
  decErrSet_a: assert property (decodeError != 4'h0 |=>
    (laneStat_r[11:8] & $past(decodeError)) == $past(decodeError))
    else $error("decode error flag not set");
  prbsDrop_a: assert property (prbsError != 4'h0 |=>
    (laneStat_r[7:4] & $past(prbsError)) == 4'h0)
    else $error("test pass flag did not drop");
  prbsRestore_a: assert property (clrLane && prbsError == 4'h0 |=> laneStat_r[7:4] == 4'hf)
    else $error("test pass flag not restored by read");
  lossClear_a: assert property (clrLane && signalLossEvent == 4'h0 |=> laneStat_r[3:0] == 4'h0)
    else $error("signal loss flag not cleared by read");
  alignSet_a: assert property (alignSeen |=> alignStat_r[4])
    else $error("alignment flag not set");
  rxColClear_a: assert property (clrAlign && rxFifoCollision == 4'h0 |=> alignStat_r[3:0] == 4'h0)
    else $error("rx collision flag not cleared by read");
  powerDownOff_a: assert property (!enSync |=>
    powerDown && txSerialOe == 4'h0 && rxParallelDataOe == 4'h0)
    else $error("outputs driven while powered down");
  globalLoop_a: assert property (ctrlLoop_r && enSync |=> loopbackEn == 4'hf)
    else $error("global loopback not applied to all lanes");
  loopFloat_a: assert property ((loopbackEn & txSerialOe) == 4'h0)
    else $error("serial output driven during loopback");
  porHold_a: assert property (porActive |->
    rxParallelDataHigh && rxRecoveredClockEn == 4'h0 && rxParallelDataOe == 4'h0)
    else $error("outputs not held during power-on reset");
  porEnd_a: assert property (porFinish |-> porCnt_r == POR_W'(POR_CYCLES - 1) ##1 !porActive)
    else $error("power-on reset length wrong");
  pinMirror_a: assert property (pinSel[0] == qlst_pkg::PINSEL_LOSS |=>
    multifunctionPin[0] == $past(laneStat_r[0]))
    else $error("multifunction pin does not mirror signal loss");
  eventKept_a: assert property (clrLane && txFifoCollision[0] |=> laneStat_r[12])
    else $error("event lost during clearing read");
  taDrive_a: assert property (taDrive |=> mdioOe && !mdioOut)
    else $error("turnaround zero not driven");
endmodule
`default_nettype wire

// File: dv/qlst_mdio_station.sv
`timescale 1ns/10ps
`default_nettype none
module qlst_mdio_station (
  output logic mdc,
  output logic drvEn,
  output logic drvBit,
  input wire logic line
);
  initial begin
    mdc = 1'b0;
    drvEn = 1'b0;
    drvBit = 1'b1;
  end

  // Management clock stands still low between frames
  task automatic tick();
    #24 mdc = 1'b1;
    #24 mdc = 1'b0;
  endtask

  // Bit changes just after the falling edge, settled well before the rise
  task automatic sendBit(input logic b);
    drvEn = 1'b1;
    drvBit = b;
    tick();
  endtask

  task automatic xfer(input logic [4:0] phy, input logic [1:0] op, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rdata);
    logic [13:0] hdr;
    hdr = {qlst_pkg::FRAME_START, op, phy, ra};
    rdata = 16'h0000;
    repeat (32) sendBit(1'b1);
    for (int i = 13; i >= 0; i--) sendBit(hdr[i]);
    if (op == qlst_pkg::OP_WRITE) begin
      sendBit(1'b1);
      sendBit(1'b0);
      for (int i = 15; i >= 0; i--) sendBit(wd[i]);
    end else begin
      // Line handed over for both turnaround bits
      drvEn = 1'b0;
      tick();
      tick();
      for (int i = 15; i >= 0; i--) begin
        #24 mdc = 1'b1;
        rdata[i] = line;
        #24 mdc = 1'b0;
      end
    end
    drvEn = 1'b0;
    tick();
  endtask
endmodule
`default_nettype wire

// File: dv/tb_qlst_status_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_qlst_status_ctrl;
  localparam int PORC = 20;
  localparam logic [4:0] PHY = 5'h03;
  logic clk, rstn, mdcPin, mdioOut, mdioOe, stEn, stBit, mdioLine;
  logic enablePin, ioModeHstlPin, alignSeen, powerDown, porActive, rxParallelDataHigh;
  logic [3:0] laneLoopbackPin, txFifoCollision, decodeError, prbsError, signalLossEvent;
  logic [3:0] rxFifoCollision, commaDetect, loopbackEn, txSerialOe, rxParallelDataOe;
  logic [3:0] rxRecoveredClockEn, multifunctionPin;
  int n_errors = 0;
  int check_count = 0;

  // Pull-up holds the line high when nobody drives it
  assign mdioLine = mdioOe ? mdioOut : (stEn ? stBit : 1'b1);

  qlst_status_ctrl #(.POR_CYCLES(PORC), .PHY_ADDR(PHY)) qlst_status_ctrl_inst (
    .clk(clk), .rstn(rstn), .mdcPin(mdcPin), .mdioIn(mdioLine), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .enablePin(enablePin), .ioModeHstlPin(ioModeHstlPin),
    .laneLoopbackPin(laneLoopbackPin), .txFifoCollision(txFifoCollision),
    .decodeError(decodeError), .prbsError(prbsError), .signalLossEvent(signalLossEvent),
    .alignSeen(alignSeen), .rxFifoCollision(rxFifoCollision), .commaDetect(commaDetect),
    .powerDown(powerDown), .porActive(porActive), .loopbackEn(loopbackEn),
    .txSerialOe(txSerialOe), .rxParallelDataOe(rxParallelDataOe),
    .rxParallelDataHigh(rxParallelDataHigh), .rxRecoveredClockEn(rxRecoveredClockEn),
    .multifunctionPin(multifunctionPin));

  qlst_mdio_station qlst_mdio_station_inst (.mdc(mdcPin), .drvEn(stEn), .drvBit(stBit),
    .line(mdioLine));

  // Core clock stands in for the board reference clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chkReg(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkPin(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic regWr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] v;
    qlst_mdio_station_inst.xfer(PHY, qlst_pkg::OP_WRITE, ra, wd, v);
    step(2);
  endtask

  task automatic regChk(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] v;
    qlst_mdio_station_inst.xfer(phy, qlst_pkg::OP_READ, ra, 16'h0000, v);
    chkReg(v, exp);
  endtask

  task automatic t_por();
    int n;
    chkPin({3'h0, porActive}, 4'h1);
    chkPin({3'h0, rxParallelDataHigh}, 4'h1);
    chkPin(rxRecoveredClockEn, 4'h0);
    n = 0;
    while (porActive !== 1'b0 && n < 200) begin
      step(1);
      n++;
    end
    chkReg(16'(n >= PORC && n <= PORC + 4), 16'h0001);
    step(4);
    chkPin(rxRecoveredClockEn, 4'hf);
    chkPin({3'h0, rxParallelDataHigh}, 4'h0);
    chkPin(rxParallelDataOe, 4'hf);
    chkPin(txSerialOe, 4'hf);
    regChk(PHY, qlst_pkg::REG_LANE_STAT, 16'h00f0);
    regChk(PHY, qlst_pkg::REG_ALIGN_STAT, 16'h0000);
  endtask

  task automatic t_events();
    logic [3:0] p;
    for (int k = 0; k < 2; k++) begin
      p = k ? 4'ha : 4'h5;
      txFifoCollision = p;
      decodeError = ~p;
      prbsError = p;
      signalLossEvent = ~p;
      rxFifoCollision = p;
      alignSeen = 1'b1;
      step(1);
      {txFifoCollision, decodeError, prbsError, signalLossEvent, rxFifoCollision} = '0;
      alignSeen = 1'b0;
      regChk(PHY, qlst_pkg::REG_LANE_STAT, {p, ~p, ~p, ~p});
      regChk(PHY, qlst_pkg::REG_LANE_STAT, 16'h00f0);
      regChk(PHY, qlst_pkg::REG_ALIGN_STAT, {11'h0, 1'b1, p});
      regChk(PHY, qlst_pkg::REG_ALIGN_STAT, 16'h0000);
    end
  endtask

  // Events held until the snapshot edge, when the first data bit rises
  task automatic t_race();
    logic [15:0] v;
    int n;
    txFifoCollision = 4'h8;
    step(1);
    txFifoCollision = 4'h0;
    signalLossEvent = 4'h1;
    prbsError = 4'h2;
    fork
      qlst_mdio_station_inst.xfer(PHY, qlst_pkg::OP_READ, qlst_pkg::REG_LANE_STAT, 16'h0, v);
      begin
        n = 0;
        while (!(mdioOe === 1'b1 && mdioOut === 1'b1) && n < 2000) begin
          step(1);
          n++;
        end
        signalLossEvent = 4'h0;
        prbsError = 4'h0;
        if (n >= 2000) begin
          n_errors++;
          wrap_up();
        end
      end
    join
    chkReg(v, 16'h80d1);
    regChk(PHY, qlst_pkg::REG_LANE_STAT, 16'h00d1);
    regChk(PHY, qlst_pkg::REG_LANE_STAT, 16'h00f0);
  endtask

  task automatic t_regs();
    regWr(qlst_pkg::REG_LANE_STAT, 16'hff0f);
    regChk(PHY, qlst_pkg::REG_LANE_STAT, 16'h00f0);
    regChk(PHY, 5'h1f, 16'h0000);
    // Wrong address: nobody drives, pull-up reads back
    regChk(PHY ^ 5'h01, qlst_pkg::REG_LANE_STAT, 16'hffff);
  endtask

  // No datapath here: the loop routing and float stand in for the data compare
  task automatic t_loop();
    for (int i = 0; i < 4; i++) begin
      laneLoopbackPin = 4'(1 << i);
      step(4);
      chkPin(loopbackEn, 4'(1 << i));
      chkPin(txSerialOe, ~4'(1 << i));
      laneLoopbackPin = 4'h0;
      regWr(qlst_pkg::REG_LCFG_A + 5'(i), 16'h0008);
      chkPin(loopbackEn, 4'(1 << i));
      chkPin(txSerialOe, ~4'(1 << i));
      regWr(qlst_pkg::REG_LCFG_A + 5'(i), 16'h0000);
    end
    regWr(qlst_pkg::REG_CTRL, 16'h4000);
    chkPin(loopbackEn, 4'hf);
    regChk(PHY, qlst_pkg::REG_CTRL, 16'h4000);
    chkPin(txSerialOe, 4'h0);
    regWr(qlst_pkg::REG_CTRL, 16'h0000);
    chkPin(loopbackEn, 4'h0);
  endtask

  task automatic t_pdown();
    laneLoopbackPin = 4'hf;
    enablePin = 1'b0;
    step(4);
    chkPin({3'h0, powerDown}, 4'h1);
    chkPin(txSerialOe, 4'h0);
    chkPin(rxParallelDataOe, 4'h0);
    chkPin(loopbackEn, 4'h0);
    enablePin = 1'b1;
    laneLoopbackPin = 4'h0;
    step(4);
    chkPin({3'h0, powerDown}, 4'h0);
    chkPin(rxParallelDataOe, 4'hf);
  endtask

  task automatic t_pinsel();
    logic [3:0] mx [4] = '{4'hf, 4'ha, 4'h6, 4'hc};
    ioModeHstlPin = 1'b1;
    commaDetect = 4'ha;
    signalLossEvent = 4'h6;
    prbsError = 4'h3;
    step(1);
    signalLossEvent = 4'h0;
    prbsError = 4'h0;
    for (int m = 0; m < 4; m++) begin
      regWr(qlst_pkg::REG_GCFG, 16'(m) << 9);
      chkPin(multifunctionPin, mx[m]);
    end
    regWr(qlst_pkg::REG_GCFG, 16'h0000);
    // Lane A alone on its own select: signal loss (clear), the rest still the level pin
    regWr(qlst_pkg::REG_LCFG_A, 16'h0400);
    chkPin(multifunctionPin, 4'he);
    regChk(PHY, qlst_pkg::REG_LCFG_A, 16'h0400);
    regWr(qlst_pkg::REG_LCFG_A, 16'h0000);
    regChk(PHY, qlst_pkg::REG_LANE_STAT, 16'h00c6);
  endtask

  initial begin
    rstn = 1'b0;
    enablePin = 1'b1;
    ioModeHstlPin = 1'b0;
    alignSeen = 1'b0;
    laneLoopbackPin = 4'h0;
    {txFifoCollision, decodeError, prbsError, signalLossEvent, rxFifoCollision} = '0;
    commaDetect = 4'h0;
    repeat (20) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_por();
    t_events();
    t_race();
    t_regs();
    t_loop();
    t_pdown();
    t_pinsel();
    wrap_up();
  end
endmodule
`default_nettype wire
